//--- include/mqrps_consts.svh
`ifndef MQRPS_CONSTS_SVH
`define MQRPS_CONSTS_SVH
`define MQRPS_DW        36
`define MQRPS_SELW      5
`define MQRPS_NQ        4
`define MQRPS_IDW       3
`define MQRPS_SOP_BIT   32
`define MQRPS_EOP_BIT   33
`define MQRPS_AE_LEVEL  2
`define MQRPS_CLK_MHZ   25
`define MQRPS_CFG_NS    400
`define MQRPS_CFG_CYC   ((`MQRPS_CFG_NS*`MQRPS_CLK_MHZ+999)/1000)
`define MQRPS_A_CTRL    8'h00
`define MQRPS_A_SEL     8'h04
`define MQRPS_A_FSEL    8'h08
`define MQRPS_A_READ    8'h0c
`define MQRPS_A_DATA    8'h10
`define MQRPS_A_FLAGS   8'h14
`define MQRPS_A_IST     8'h18
`define MQRPS_A_ICLR    8'h1c
`define MQRPS_A_IEN     8'h20
`define MQRPS_EV_WORD   0
`define MQRPS_EV_SEL    1
`define MQRPS_EV_PKT    2
`define MQRPS_NEV       3
`define MQRPS_RESP_OK   2'h0
`define MQRPS_RESP_ERR  2'h2
`endif

//--- include/mqrps_pkg.sv
`default_nettype none
`include "mqrps_consts.svh"
package mqrps_pkg;
  typedef logic [`MQRPS_DW-1:0] mqrps_word_type;
  typedef enum logic [1:0] {
    MQRPS_IDLE = 2'b00,
    MQRPS_STRB = 2'b01,
    MQRPS_RD   = 2'b10
  } mqrps_host_state_type;
endpackage
`default_nettype wire

//--- include/mqrps_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "mqrps_consts.svh"
interface mqrps_if;
  logic                   read_strobe_n;
  logic                   out_enable_n;
  logic                   read_queue_select_strobe;
  logic [`MQRPS_SELW-1:0] read_select_bus;
  logic                   flag_device_strobe;
  logic [`MQRPS_DW-1:0]   q_data;
  logic                   q_drive_n;
  logic                   output_valid_flag;
  logic                   almost_empty_flag;
  logic                   packet_ready_flag;
  logic [`MQRPS_NQ-1:0]   flag_status_bus;
  logic                   flag_drive_n;
  logic                   flag_cycle_marker;
  logic                   config_done_out;
  modport dev (
    input  read_strobe_n, out_enable_n, read_queue_select_strobe,
    input  read_select_bus, flag_device_strobe,
    output q_data, q_drive_n, output_valid_flag, almost_empty_flag,
    output packet_ready_flag, flag_status_bus, flag_drive_n,
    output flag_cycle_marker, config_done_out
  );
  modport host (
    output read_strobe_n, out_enable_n, read_queue_select_strobe,
    output read_select_bus, flag_device_strobe,
    input  q_data, q_drive_n, output_valid_flag, almost_empty_flag,
    input  packet_ready_flag, flag_status_bus, flag_drive_n,
    input  flag_cycle_marker, config_done_out
  );
endinterface
`default_nettype wire

//--- hdl/mqrps_queue.sv
`timescale 1ns/10ps
`default_nettype none
module mqrps_queue
  import mqrps_pkg::*;
#(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic                           ce,
  input  wire logic                           push_valid,
  input  wire logic [WIDTH-1:0]               push_data,
  output logic                                push_ready,
  input  wire logic                           pop,
  output logic [WIDTH-1:0]                    head,
  output logic [$clog2(DEPTH+1)-1:0]          level,
  output logic                                empty
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);
  // Pointers wrap naturally, so DEPTH must be a power of two
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [LW-1:0]               cnt;
  } mqrps_queue_state_type;
  mqrps_queue_state_type q, d;
  logic push_ok;
  logic pop_ok;

  assign push_ready = q.cnt != LW'(DEPTH);
  assign empty      = q.cnt == '0;
  assign level      = q.cnt;
  assign head       = q.mem[q.rp];

  always_comb begin
    d = q;
    push_ok = push_valid && push_ready;
    pop_ok  = pop && !empty;
    if (push_ok) begin
      d.mem[q.wp] = push_data;
      d.wp = q.wp + 1'b1;
    end
    if (pop_ok)
      d.rp = q.rp + 1'b1;
    d.cnt = q.cnt + LW'(push_ok) - LW'(pop_ok);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      q <= '0;
    else if (ce)
      q <= d;
  end
endmodule
`default_nettype wire

//--- hdl/mqrps_dev.sv
`timescale 1ns/10ps
`default_nettype none
`include "mqrps_consts.svh"
module mqrps_dev
  import mqrps_pkg::*;
#(
  parameter int DEPTH   = 16,
  parameter int CFG_CYC = `MQRPS_CFG_CYC
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  input  wire logic [`MQRPS_IDW-1:0] device_id,
  input  wire logic                  packet_mode,
  input  wire logic                  flag_strobed_mode,
  input  wire logic                  serial_enable_in_n,
  input  wire logic                  wr_valid,
  input  wire logic [1:0]            wr_queue,
  input  wire logic [`MQRPS_DW-1:0]  wr_data,
  output logic                       wr_ready,
  input  wire logic                  expansion_token_in,
  output logic                       expansion_token_out,
  mqrps_if.dev                       link
);
  localparam int NQ = `MQRPS_NQ;
  localparam int LW = $clog2(DEPTH+1);
  localparam int CW = $clog2(CFG_CYC+1);

  typedef struct packed {
    logic [1:0]               sel_queue;
    logic                     selected;
    logic                     first_word_fallthrough_pend;
    logic [`MQRPS_DW-1:0]     q_out;
    logic                     ov;
    logic                     ae;
    logic                     pr;
    logic [NQ-1:0][LW-1:0]    eop_cnt;
    logic [`MQRPS_IDW-1:0]    poll_cnt;
    logic [`MQRPS_IDW-1:0]    flag_dev;
    logic [NQ-1:0]            flag_bus;
    logic                     flag_drv_n;
    logic                     marker;
    logic [CW-1:0]            cfg_cnt;
    logic                     programmed;
    logic                     cfg_done_n;
    logic                     token_out;
  } mqrps_dev_state_type;

  localparam mqrps_dev_state_type DEV_RST = '{
    flag_drv_n: 1'b1,
    cfg_done_n: 1'b1,
    default:    '0
  };

  mqrps_dev_state_type q, d;
  logic [NQ-1:0]                 push_vec;
  logic [NQ-1:0]                 ready_vec;
  logic [NQ-1:0]                 pop_vec;
  logic [NQ-1:0]                 empty_vec;
  logic [NQ-1:0][`MQRPS_DW-1:0]  head_vec;
  logic [NQ-1:0][LW-1:0]         level_vec;
  logic                          read_go;

  // High device bits of the select bus against our identifier
  function automatic logic dev_match(
    input logic [`MQRPS_SELW-1:0] bus,
    input logic [`MQRPS_IDW-1:0]  id
  );
    dev_match = bus[`MQRPS_SELW-1:2] == id;
  endfunction

  function automatic logic ae_of(input logic [LW-1:0] lvl);
    ae_of = lvl <= LW'(`MQRPS_AE_LEVEL);
  endfunction

  // In packet mode only start and end markers survive in the top bits
  function automatic logic [`MQRPS_DW-1:0] shape_word(
    input logic [`MQRPS_DW-1:0] w,
    input logic                 pkt
  );
    shape_word = w;
    if (pkt)
      shape_word[`MQRPS_DW-1:`MQRPS_EOP_BIT+1] = '0;
  endfunction

  genvar g;
  for (g = 0; g < NQ; g++) begin : g_queue
    assign push_vec[g] = wr_valid && wr_queue == 2'(g);
    mqrps_queue #(
      .WIDTH (`MQRPS_DW),
      .DEPTH (DEPTH)
    ) u_queue (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .ce         (ce),
      .push_valid (push_vec[g]),
      .push_data  (wr_data),
      .push_ready (ready_vec[g]),
      .pop        (pop_vec[g]),
      .head       (head_vec[g]),
      .level      (level_vec[g]),
      .empty      (empty_vec[g])
    );
  end

  assign wr_ready = ready_vec[wr_queue];

  always_comb begin
    d = q;
    pop_vec = '0;
    read_go = !link.read_strobe_n && !link.out_enable_n
              && q.selected;
    // Old queue is still read here even if a new select lands now
    if (q.first_word_fallthrough_pend || read_go) begin
      d.first_word_fallthrough_pend = 1'b0;
      d.ov = !empty_vec[q.sel_queue];
      pop_vec[q.sel_queue] = !empty_vec[q.sel_queue];
      if (!empty_vec[q.sel_queue])
        d.q_out = shape_word(head_vec[q.sel_queue], packet_mode);
    end
    // The controller keeps the strobe off before configuration ends
    if (link.read_queue_select_strobe) begin
      if (dev_match(link.read_select_bus, device_id)) begin
        d.sel_queue = link.read_select_bus[1:0];
        d.selected  = 1'b1;
        d.first_word_fallthrough_pend = 1'b1;
      end else begin
        d.selected  = 1'b0;
        d.first_word_fallthrough_pend = 1'b0;
      end
    end
    for (int i = 0; i < NQ; i++) begin
      d.eop_cnt[i] = q.eop_cnt[i]
        + LW'(push_vec[i] && ready_vec[i] && packet_mode
              && wr_data[`MQRPS_EOP_BIT])
        - LW'(pop_vec[i] && packet_mode
              && head_vec[i][`MQRPS_EOP_BIT]);
      d.flag_bus[i] = ae_of(level_vec[i]);
    end
    d.ae = q.selected && ae_of(level_vec[q.sel_queue]);
    d.pr = packet_mode && q.selected
           && q.eop_cnt[q.sel_queue] != '0;
    // Neither flag mode looks at the read strobe
    if (!flag_strobed_mode) begin
      d.poll_cnt   = q.poll_cnt + 1'b1;
      d.marker     = q.poll_cnt == '0;
      d.flag_drv_n = q.poll_cnt != device_id;
    end else begin
      d.marker = 1'b0;
      if (link.flag_device_strobe)
        d.flag_dev = link.read_select_bus[`MQRPS_SELW-1:2];
      d.flag_drv_n = d.flag_dev != device_id;
    end
    if (!q.programmed) begin
      d.cfg_cnt = q.cfg_cnt + 1'b1;
      if (q.cfg_cnt == CW'(CFG_CYC - 1))
        d.programmed = 1'b1;
    end
    // Done follows the chain input once programmed, as in a cascade
    d.cfg_done_n = !(q.programmed && !serial_enable_in_n);
    // Token passes through while idle, fires when we give up the port
    d.token_out = q.selected
      ? (link.read_queue_select_strobe
         && !dev_match(link.read_select_bus, device_id))
      : expansion_token_in;
  end

  // Single clock: the read clock is aclk and is assumed free-running
  always_ff @(posedge aclk) begin
    if (!aresetn)
      q <= DEV_RST;
    else if (ce)
      q <= d;
  end

  assign link.q_data            = q.q_out;
  assign link.q_drive_n         = link.out_enable_n || !q.selected;
  assign link.output_valid_flag = q.ov;
  assign link.almost_empty_flag = q.ae;
  assign link.packet_ready_flag = q.pr;
  assign link.flag_status_bus   = q.flag_bus;
  assign link.flag_drive_n      = q.flag_drv_n;
  assign link.flag_cycle_marker = q.marker;
  assign link.config_done_out   = q.cfg_done_n;
  assign expansion_token_out    = q.token_out;
endmodule
`default_nettype wire

//--- hdl/mqrps_host.sv
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "mqrps_consts.svh"
module mqrps_host
  import mqrps_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq,
  mqrps_if.host            link
);
  localparam int NEV = `MQRPS_NEV;
  typedef struct packed {
    mqrps_host_state_type   st;
    logic                   oe_en;
    logic                   sel_req;
    logic [`MQRPS_SELW-1:0] sel_val;
    logic                   fsel_req;
    logic [`MQRPS_IDW-1:0]  fsel_val;
    logic                   rd_req;
    logic [`MQRPS_DW-1:0]   data;
    logic                   data_ok;
    logic [NEV-1:0]         ist;
    logic [NEV-1:0]         ien;
    logic                   pr_prev;
    logic                   aw_pend;
    logic [7:0]             aw_addr;
    logic                   w_pend;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [31:0]            rdata;
    logic                   rqss;
    logic                   fds;
    logic                   ren_n;
    logic [`MQRPS_SELW-1:0] bus;
  } mqrps_host_type;
  localparam mqrps_host_type HOST_RST = '{
    st: MQRPS_IDLE, ren_n: 1'b1, default: '0};
  mqrps_host_type q, d;
  logic [NEV-1:0] ev;
  logic [NEV-1:0] clr;

  // Byte lanes of a write merged into the base word o, which the one caller sets to zero
  function automatic logic [31:0] merge(input logic [31:0] o,
    input logic [31:0] n, input logic [3:0] s);
    for (int b = 0; b < 4; b++)
      merge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
  endfunction

  always_comb begin
    logic [31:0] m;
    m = merge(32'h0, q.w_data, q.w_strb);
    d = q;
    ev = '0;
    clr = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_pend = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_pend = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;
    if (q.aw_pend && q.w_pend) begin
      d.aw_pend = 1'b0;
      d.w_pend  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = `MQRPS_RESP_OK;
      case (q.aw_addr)
        `MQRPS_A_CTRL: if (q.w_strb[0]) d.oe_en = m[0];
        `MQRPS_A_SEL: begin
          d.sel_req = 1'b1;
          d.sel_val = m[`MQRPS_SELW-1:0];
        end
        `MQRPS_A_FSEL: begin
          d.fsel_req = 1'b1;
          d.fsel_val = m[`MQRPS_IDW-1:0];
        end
        `MQRPS_A_READ: d.rd_req = 1'b1;
        `MQRPS_A_ICLR: clr = m[NEV-1:0];
        `MQRPS_A_IEN:  if (q.w_strb[0]) d.ien = m[NEV-1:0];
        default:       d.bresp = `MQRPS_RESP_ERR;
      endcase
    end
    if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp  = `MQRPS_RESP_OK;
      d.rdata  = '0;
      case (s_axi_araddr)
        `MQRPS_A_CTRL:  d.rdata[0] = q.oe_en;
        `MQRPS_A_SEL:   d.rdata[`MQRPS_SELW-1:0] = q.sel_val;
        `MQRPS_A_FSEL:  d.rdata[`MQRPS_IDW-1:0] = q.fsel_val;
        `MQRPS_A_READ:  d.rdata[0] = q.rd_req;
        `MQRPS_A_DATA:  d.rdata = q.data[31:0];
        `MQRPS_A_FLAGS: d.rdata[15:0] = {q.data[`MQRPS_DW-1:32],
          link.flag_status_bus, link.flag_cycle_marker,
          link.config_done_out, link.packet_ready_flag,
          link.almost_empty_flag, link.output_valid_flag,
          q.data_ok, q.sel_req | q.fsel_req | q.rd_req,
          q.st != MQRPS_IDLE};
        `MQRPS_A_IST:   d.rdata[NEV-1:0] = q.ist;
        `MQRPS_A_ICLR:  d.rdata = '0;
        `MQRPS_A_IEN:   d.rdata[NEV-1:0] = q.ien;
        default:        d.rresp = `MQRPS_RESP_ERR;
      endcase
    end
    // Strobes last one cycle and one kind at a time
    case (q.st)
      MQRPS_IDLE: begin
        if (q.sel_req && !link.config_done_out) begin
          d.rqss = 1'b1;
          d.bus = q.sel_val;
          d.sel_req = 1'b0;
          d.st = MQRPS_STRB;
        end else if (q.fsel_req) begin
          d.fds = 1'b1;
          // Queue bits stay as they were; the device ignores them here
          d.bus = {q.fsel_val, q.bus[1:0]};
          d.fsel_req = 1'b0;
          d.st = MQRPS_STRB;
        end else if (q.rd_req) begin
          // Take the word on show, then advance past it if selected with output enabled
          d.data = link.q_data;
          d.data_ok = link.output_valid_flag;
          ev[`MQRPS_EV_WORD] = link.output_valid_flag;
          d.ren_n = 1'b0;
          d.rd_req = 1'b0;
          d.st = MQRPS_RD;
        end
      end
      MQRPS_STRB: begin
        ev[`MQRPS_EV_SEL] = q.rqss;
        d.rqss = 1'b0;
        d.fds = 1'b0;
        d.st = MQRPS_IDLE;
      end
      MQRPS_RD: begin
        d.ren_n = 1'b1;
        d.st = MQRPS_IDLE;
      end
      default: d.st = MQRPS_IDLE;
    endcase
    d.pr_prev = link.packet_ready_flag;
    ev[`MQRPS_EV_PKT] = link.packet_ready_flag && !q.pr_prev;
    d.ist = (q.ist & ~clr) | ev;
  end

  // aclk doubles as the read clock and never stops
  always_ff @(posedge aclk) begin
    if (!aresetn)
      q <= HOST_RST;
    else if (ce)
      q <= d;
  end

  assign s_axi_awready = !q.aw_pend && !q.bvalid;
  assign s_axi_wready  = !q.w_pend && !q.bvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign irq           = |(q.ist & q.ien);
  assign link.read_strobe_n            = q.ren_n;
  assign link.out_enable_n             = !q.oe_en;
  assign link.read_queue_select_strobe = q.rqss;
  assign link.flag_device_strobe       = q.fds;
  assign link.read_select_bus          = q.bus;
endmodule
`default_nettype wire

//--- verif/mqrps_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "mqrps_consts.svh"
module mqrps_sva
  import mqrps_pkg::*;
#(
  parameter logic [2:0] DEV_ID = 3'h5
) (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic                   flag_strobed_mode,
  input wire logic                   read_strobe_n,
  input wire logic                   out_enable_n,
  input wire logic                   read_queue_select_strobe,
  input wire logic [`MQRPS_SELW-1:0] read_select_bus,
  input wire logic                   flag_device_strobe,
  input wire logic [`MQRPS_DW-1:0]   q_data,
  input wire logic                   q_drive_n,
  input wire logic                   output_valid_flag,
  input wire logic                   flag_drive_n,
  input wire logic                   flag_cycle_marker,
  input wire logic                   config_done_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_strobe;
    read_queue_select_strobe || flag_device_strobe;
  endsequence
  sequence s_here;
    read_queue_select_strobe && read_select_bus[4:2] == DEV_ID;
  endsequence
  sequence s_away;
    read_queue_select_strobe && read_select_bus[4:2] != DEV_ID;
  endsequence
  property p_excl;
    !(read_queue_select_strobe && flag_device_strobe);
  endproperty
  property p_gap;
    s_strobe |=> !(read_queue_select_strobe || flag_device_strobe);
  endproperty
  property p_cfg;
    read_queue_select_strobe |-> !config_done_out;
  endproperty
  property p_hold;
    $changed(read_select_bus) |-> s_strobe;
  endproperty
  property p_oe;
    out_enable_n |-> q_drive_n;
  endproperty
  // A word moves only on a pop or one edge after a selection
  property p_quiet;
    output_valid_flag && read_strobe_n && !$past(read_queue_select_strobe)
      |=> $stable(q_data);
  endproperty
  property p_here;
    s_here |=> q_drive_n == out_enable_n;
  endproperty
  property p_away;
    s_away |=> q_drive_n [*2];
  endproperty
  property p_fsel;
    flag_strobed_mode && flag_device_strobe
      |=> flag_drive_n == (read_select_bus[4:2] != DEV_ID);
  endproperty
  // Eight poll slots, one per possible device
  property p_marker;
    disable iff (!aresetn || flag_strobed_mode)
    flag_cycle_marker |=> (!flag_cycle_marker) [*7] ##1 flag_cycle_marker;
  endproperty
  a_excl: assert property (p_excl)
    else $error("select and flag strobes together");
  a_gap: assert property (p_gap)
    else $error("strobe held longer than one cycle");
  a_cfg: assert property (p_cfg)
    else $error("queue select before configuration done");
  a_hold: assert property (p_hold)
    else $error("select bus moved without a strobe");
  a_oe: assert property (p_oe)
    else $error("output driven while drive disabled");
  a_quiet: assert property (p_quiet)
    else $error("output word changed without a read");
  a_here: assert property (p_here)
    else $error("own queue select not taken");
  a_away: assert property (p_away)
    else $error("foreign select left device driving");
  a_fsel: assert property (p_fsel)
    else $error("flag bus owner wrong after flag strobe");
  a_marker: assert property (p_marker)
    else $error("poll marker period wrong");
endmodule
`default_nettype wire

//--- verif/multiqueue_read_port_select_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "mqrps_consts.svh"
`define CHK(got, exp) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module multiqueue_read_port_select_tb_top
  import mqrps_pkg::*;
;
  localparam logic [2:0] DEV_ID = 3'h5;
  localparam int         LIM    = 400;
  logic                  aclk, aresetn, flag_strobed_mode;
  logic                  wr_valid, wr_ready, expansion_token_in;
  logic                  token_out, tok;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready, irq;
  logic [1:0]            wr_queue, bresp, rresp, resp;
  logic [7:0]            awaddr, araddr;
  logic [3:0]            wstrb;
  logic [31:0]           wdata, rdata, rd_data;
  mqrps_word_type        wr_data;
  mqrps_word_type        exp_q[4][$];
  int                    errors, n_checks;
  mqrps_if link ();
  mqrps_dev i_mqrps_dev (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .device_id(DEV_ID), .packet_mode(1'b1),
    .flag_strobed_mode(flag_strobed_mode), .serial_enable_in_n(1'b0),
    .wr_valid(wr_valid), .wr_queue(wr_queue), .wr_data(wr_data),
    .wr_ready(wr_ready), .expansion_token_in(expansion_token_in),
    .expansion_token_out(token_out), .link(link));
  mqrps_host i_mqrps_host (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .link(link));
  mqrps_sva #(.DEV_ID(DEV_ID)) i_mqrps_sva (.aclk(aclk), .aresetn(aresetn),
    .flag_strobed_mode(flag_strobed_mode),
    .read_strobe_n(link.read_strobe_n), .out_enable_n(link.out_enable_n),
    .read_queue_select_strobe(link.read_queue_select_strobe),
    .read_select_bus(link.read_select_bus),
    .flag_device_strobe(link.flag_device_strobe), .q_data(link.q_data),
    .q_drive_n(link.q_drive_n), .output_valid_flag(link.output_valid_flag),
    .flag_drive_n(link.flag_drive_n),
    .flag_cycle_marker(link.flag_cycle_marker),
    .config_done_out(link.config_done_out));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    expansion_token_in <= 1'($urandom());
  end
  task automatic finish_test();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic stall(input logic ok);
    if (!ok) begin
      $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      errors++;
      finish_test();
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hf};
    {awvalid, wvalid, bready} <= 3'h7;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < LIM);
    resp = bresp;
    bready <= 1'b0;
    stall(n < LIM);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    n = 0;
    do begin
      @(posedge aclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < LIM);
    {rd_data, resp} = {rdata, rresp};
    rready <= 1'b0;
    stall(n < LIM);
  endtask
  // Polls the status word until the masked bits clear
  task automatic wait_clear(input logic [31:0] mask);
    int n;
    n = 0;
    do begin
      axi_rd(`MQRPS_A_FLAGS);
      n++;
    end while ((rd_data & mask) != 0 && n < 60);
    stall((rd_data & mask) == 0);
  endtask
  task automatic push(input logic [1:0] q, input mqrps_word_type w);
    int n;
    @(posedge aclk);
    {wr_valid, wr_queue, wr_data} <= {1'b1, q, w};
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (wr_ready !== 1'b1 && n < LIM);
    wr_valid <= 1'b0;
    exp_q[q].push_back(w);
    stall(n < LIM);
  endtask
  function automatic logic [31:0] sel_word(input logic [2:0] id,
                                           input logic [1:0] q);
    return {27'h0, id, q};
  endfunction
  initial begin
    int s;
    logic [1:0] q;
    logic [2:0] id;
    aresetn = 1'b0;
    flag_strobed_mode = 1'b0;
    {wr_valid, wr_queue, wr_data} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    s = $urandom(32'he65be47d);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`MQRPS_A_FLAGS);
    `CHK(rd_data[6], 1'b1)
    wait_clear(32'h40);
    axi_rd(8'h40);
    `CHK(resp, `MQRPS_RESP_ERR)
    axi_wr(8'h44, 32'h0);
    `CHK(resp, `MQRPS_RESP_ERR)
    axi_wr(`MQRPS_A_IEN, 32'h2);
    `CHK(resp, `MQRPS_RESP_OK)
    // Queue 0 stays empty to see the valid flag stay low
    for (int i = 1; i < 4; i++)
      repeat ($urandom_range(5, 1))
        push(2'(i), {2'h0, 2'($urandom()), 32'($urandom())});
    s = $urandom_range(3, 0);
    for (int i = 0; i < 4; i++) begin
      q = 2'(s + i);
      axi_wr(`MQRPS_A_CTRL, 32'h0);
      axi_wr(`MQRPS_A_SEL, sel_word(DEV_ID, q ^ 2'h2));
      // A word shown but never read is dropped by the next selection
      if (exp_q[q ^ 2'h2].size() != 0)
        void'(exp_q[q ^ 2'h2].pop_front());
      axi_wr(`MQRPS_A_SEL, sel_word(DEV_ID, q));
      wait_clear(32'h3);
      axi_wr(`MQRPS_A_READ, 32'h0);
      axi_wr(`MQRPS_A_CTRL, 32'h1);
      wait_clear(32'h3);
      `CHK(rd_data[3], exp_q[q].size() != 0)
      while (exp_q[q].size() != 0) begin
        axi_wr(`MQRPS_A_READ, 32'h0);
        wait_clear(32'h3);
        `CHK(rd_data[15:12], exp_q[q][0][35:32])
        axi_rd(`MQRPS_A_DATA);
        `CHK(rd_data, exp_q[q][0][31:0])
        void'(exp_q[q].pop_front());
      end
      wait_clear(32'h3);
      `CHK(rd_data[3], 1'b0)
    end
    `CHK(irq, 1'b1)
    axi_wr(`MQRPS_A_IEN, 32'h0);
    @(posedge aclk);
    `CHK(irq, 1'b0)
    axi_rd(`MQRPS_A_IST);
    `CHK(rd_data[1], 1'b1)
    axi_wr(`MQRPS_A_IEN, 32'h2);
    @(posedge aclk);
    `CHK(irq, 1'b1)
    axi_wr(`MQRPS_A_ICLR, 32'h2);
    @(posedge aclk);
    `CHK(irq, 1'b0)
    axi_rd(`MQRPS_A_IST);
    `CHK(rd_data[1], 1'b0)
    axi_rd(`MQRPS_A_ICLR);
    `CHK(rd_data, 32'h0)
    axi_wr(`MQRPS_A_SEL, sel_word(DEV_ID ^ 3'h1, 2'h1));
    wait_clear(32'h3);
    `CHK(link.q_drive_n, 1'b1)
    // Deselected, the token input passes through one cycle later
    repeat (4) begin
      @(posedge aclk);
      tok = expansion_token_in;
      @(posedge aclk);
      `CHK(token_out, tok)
    end
    flag_strobed_mode <= 1'b1;
    // Low select bits still hold the last queue number here
    for (int i = 0; i < 2; i++) begin
      id = (i == 0) ? DEV_ID : DEV_ID ^ 3'(1 + $urandom_range(6, 0));
      axi_wr(`MQRPS_A_FSEL, {29'h0, id});
      wait_clear(32'h3);
      `CHK(link.flag_drive_n, id != DEV_ID)
    end
    finish_test();
  end
endmodule
`default_nettype wire
